// ### vcd_pkg.sv
package vcd_pkg;
  // ==================================================
  // widths
  localparam int unsigned CODE_W   = 8;
  localparam int unsigned CHAN_N   = 3;
  localparam int unsigned DCNT_W   = 2;
  localparam int unsigned WORD_W   = CODE_W * CHAN_N;
  // ==================================================
  // clamp target codes, out of 256
  localparam logic [7:0] CLAMP_LOW_CODE  = 8'h10;
  localparam logic [7:0] CLAMP_MID_CODE  = 8'h80;
  localparam logic [7:0] CLAMP_OPEN_CODE = 8'h40;
  // ==================================================
  // channel order inside a word: luma/green, red/u, blue/v
  localparam int unsigned CH_LUMA  = 0;
  // ==================================================
  // output code limits
  localparam logic [7:0] CODE_MIN  = 8'h00;
  localparam logic [7:0] CODE_MAX  = 8'hFF;
  // ==================================================
  // pipeline: output word appears on the third rising edge after sampling
  localparam int unsigned LAT_RISE = 3;
  // ==================================================
  // clamp mode pin decode
  typedef enum logic [1:0] {VCD_MODE_RGB, VCD_MODE_YUV_LOW, VCD_MODE_YUV_OPEN} vcd_mode_e;
  // dither offset in signed half steps, per counter value
  typedef logic signed [2:0] vcd_half_t;
  localparam vcd_half_t DITH_HALF0 = 3'sd0;
  localparam vcd_half_t DITH_HALF1 = 3'sd1;
  localparam vcd_half_t DITH_HALF2 = 3'sd2;
  localparam vcd_half_t DITH_HALF3 = 3'sd1;
endpackage : vcd_pkg

// ### vcd_stream_if.sv
`timescale 1ns/1ns
interface vcd_stream_if #(
  parameter int unsigned W = 24
);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport tx (output data, output valid, input ready);
  modport rx (input data, input valid, output ready);
endinterface : vcd_stream_if

// ### vcd_skid_buf.sv
`timescale 1ns/1ns
module vcd_skid_buf #(
  parameter int unsigned W = 24
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // streams
  vcd_stream_if.rx in_s,
  vcd_stream_if.tx out_s
);
  // ==================================================
  // two entries, flops addressed by index
  logic [W-1:0] mem_reg [2];
  logic         wr_ptr_reg;
  logic         rd_ptr_reg;
  logic [1:0]   cnt_reg;
  logic         push;
  logic         pop;

  if (W < 1) begin : g_bad_width
    $error("vcd_skid_buf: width must be positive");
  end

  assign in_s.ready  = (cnt_reg != 2'd2);
  assign out_s.valid = (cnt_reg != 2'd0);
  assign out_s.data  = mem_reg[rd_ptr_reg];
  assign push        = in_s.valid && in_s.ready;
  assign pop         = out_s.valid && out_s.ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_s.data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      cnt_reg    <= 2'd0;
    end else begin
      if (push) wr_ptr_reg <= ~wr_ptr_reg;
      if (pop)  rd_ptr_reg <= ~rd_ptr_reg;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : vcd_skid_buf

// ### vcd_ctrl.sv
// Functional notes
// - mode pin low: all three channels clamp to 16 of 256.
// - yuv: chroma clamps mid-scale; luma 16 when pin high, 64 when open.
// - while line sync high, clamps integrate input minus clamp reference.
// - on line sync falling edge each clamp latches integrator sign bit.
// - while line sync low, apply sink or source chosen by latched bit.
// - dither offset changes line to line in half-lsb steps.
// - whole-lsb dither offset is subtracted from the output word.
// - dither pattern comes from a counter advanced once per line.
// - dither counter cleared on every second frame sync pulse.
// - each channel removes the dither amount with a binary adder.
// - frame sync held low disables dither offset and correction.
// - output extremes are 00 and FE or FF, by counter state.
// - out-of-range inputs give lowest or highest code, else true code.
// - sample on falling conversion clock, output on rising 2.5 cycles later.
`timescale 1ns/1ns
module vcd_ctrl #(
  parameter int unsigned CHANS = 3
) (
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     srst,
  // pins from the timing source
  input  wire logic                     conv_clk_pin,
  input  wire logic                     line_sync_input,
  input  wire logic                     frame_sync_input,
  input  wire logic                     mode_pin_level,
  input  wire logic                     mode_pin_open,
  // comparator side
  input  wire logic [CHANS*8-1:0]       raw_code,
  input  wire logic [CHANS-1:0]         integ_sign,
  // clamp drive
  output logic                          clamp_integrate,
  output logic [CHANS*8-1:0]            clamp_ref_code,
  output logic [CHANS-1:0]              clamp_sink,
  output logic [CHANS-1:0]              clamp_source,
  // dither drive to the analog offset
  output logic signed [2:0]             dither_half_steps,
  // output word stream
  output logic [CHANS*8-1:0]            out_data,
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic                          in_ready
);
  // ==================================================
  // pin synchronisers: change counts when stage 2 and 3 agree
  localparam int unsigned NPIN = 5;
  logic [NPIN-1:0] pin_s1_reg;
  logic [NPIN-1:0] pin_s2_reg;
  logic [NPIN-1:0] pin_s3_reg;
  logic [NPIN-1:0] pin_reg;
  logic            cclk_fall;
  logic            cclk_rise;
  logic            line_rise;
  logic            line_fall;
  logic            frame_fall;

  if (CHANS != vcd_pkg::CHAN_N) begin : g_bad_chans
    $error("vcd_ctrl: three channels only");
  end

  // filter runs through reset: levels match the pins at release, no false edge
  always_ff @(posedge ref_clk) begin
    pin_s1_reg <= {mode_pin_open, mode_pin_level, frame_sync_input,
                   line_sync_input, conv_clk_pin};
    pin_s2_reg <= pin_s1_reg;
    pin_s3_reg <= pin_s2_reg;
  end

  generate
    for (genvar p = 0; p < NPIN; p++) begin : g_pin
      always_ff @(posedge ref_clk) begin
        if (pin_s2_reg[p] == pin_s3_reg[p]) begin
          pin_reg[p] <= pin_s3_reg[p];
        end
      end
    end
  endgenerate

  // edges of the filtered levels
  logic [NPIN-1:0] pin_new;
  always_comb begin
    pin_new = pin_reg;
    for (int p = 0; p < NPIN; p++) begin
      if (pin_s2_reg[p] == pin_s3_reg[p]) pin_new[p] = pin_s3_reg[p];
    end
  end
  assign cclk_fall  = pin_reg[0] && !pin_new[0];
  assign cclk_rise  = !pin_reg[0] && pin_new[0];
  assign line_rise  = !pin_reg[1] && pin_new[1];
  assign line_fall  = pin_reg[1] && !pin_new[1];
  assign frame_fall = pin_reg[2] && !pin_new[2];

  // ==================================================
  // clamp level selection
  vcd_pkg::vcd_mode_e mode;
  always_comb begin
    if (pin_reg[4])      mode = vcd_pkg::VCD_MODE_YUV_OPEN;
    else if (pin_reg[3]) mode = vcd_pkg::VCD_MODE_YUV_LOW;
    else                 mode = vcd_pkg::VCD_MODE_RGB;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      clamp_ref_code <= {CHANS{vcd_pkg::CLAMP_LOW_CODE}};
    end else begin
      for (int c = 0; c < CHANS; c++) begin
        case (mode)
          vcd_pkg::VCD_MODE_RGB: begin
            clamp_ref_code[c*8 +: 8] <= vcd_pkg::CLAMP_LOW_CODE;
          end
          vcd_pkg::VCD_MODE_YUV_LOW: begin
            clamp_ref_code[c*8 +: 8] <= (c == vcd_pkg::CH_LUMA) ?
              vcd_pkg::CLAMP_LOW_CODE : vcd_pkg::CLAMP_MID_CODE;
          end
          default: begin
            clamp_ref_code[c*8 +: 8] <= (c == vcd_pkg::CH_LUMA) ?
              vcd_pkg::CLAMP_OPEN_CODE : vcd_pkg::CLAMP_MID_CODE;
          end
        endcase
      end
    end
  end

  // ==================================================
  // clamp sequencing; relies on a sync pulse that ends inside the porch
  logic [CHANS-1:0] sign_reg;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      clamp_integrate <= 1'b0;
    end else begin
      clamp_integrate <= pin_new[1];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sign_reg <= '0;
    end else if (line_fall) begin
      sign_reg <= integ_sign;
    end
  end

  // correction idles until the first latched sign after reset
  logic sign_ok_reg;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sign_ok_reg  <= 1'b0;
      clamp_sink   <= '0;
      clamp_source <= '0;
    end else begin
      if (line_fall) sign_ok_reg <= 1'b1;
      if (pin_new[1] || !(sign_ok_reg || line_fall)) begin
        clamp_sink   <= '0;
        clamp_source <= '0;
      end else begin
        clamp_sink   <= line_fall ? integ_sign : sign_reg;
        clamp_source <= line_fall ? ~integ_sign : ~sign_reg;
      end
    end
  end

  // ==================================================
  // dither sequencer
  logic [vcd_pkg::DCNT_W-1:0] dcnt_reg;
  logic                       frame_odd_reg;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dcnt_reg      <= '0;
      frame_odd_reg <= 1'b0;
    end else begin
      if (frame_fall) frame_odd_reg <= ~frame_odd_reg;
      if (frame_fall && frame_odd_reg) begin
        dcnt_reg <= '0;
      end else if (line_rise) begin
        dcnt_reg <= dcnt_reg + 1'b1;
      end
    end
  end

  // fixed half-step table; neighbours differ by one half step
  vcd_pkg::vcd_half_t half_now;
  always_comb begin
    case (dcnt_reg)
      2'd0:    half_now = vcd_pkg::DITH_HALF0;
      2'd1:    half_now = vcd_pkg::DITH_HALF1;
      2'd2:    half_now = vcd_pkg::DITH_HALF2;
      default: half_now = vcd_pkg::DITH_HALF3;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dither_half_steps <= '0;
    end else begin
      dither_half_steps <= pin_reg[2] ? half_now : 3'sd0;
    end
  end

  // ==================================================
  // sampling, correction and 2.5-cycle pipeline
  logic signed [2:0]    whole_lsb;
  logic [CHANS*8-1:0]   corr_code;
  logic [CHANS*8-1:0]   pipe_a_reg;
  logic [CHANS*8-1:0]   pipe_b_reg;
  logic [CHANS*8-1:0]   pipe_c_reg;
  logic                 va_reg;
  logic                 vb_reg;
  logic                 vc_reg;

  // only the whole part of the offset is removed; odd halves stay
  assign whole_lsb = dither_half_steps >>> 1;

  generate
    for (genvar c = 0; c < CHANS; c++) begin : g_add
      logic signed [9:0] sum;
      assign sum = $signed({2'b00, raw_code[c*8 +: 8]}) - 10'(whole_lsb);
      always_comb begin
        if (sum < 10'sd0)
          corr_code[c*8 +: 8] = vcd_pkg::CODE_MIN;
        else if (sum > 10'sd255)
          corr_code[c*8 +: 8] = vcd_pkg::CODE_MAX;
        else
          corr_code[c*8 +: 8] = sum[7:0];
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pipe_a_reg <= '0;
      pipe_b_reg <= '0;
      pipe_c_reg <= '0;
      va_reg     <= 1'b0;
      vb_reg     <= 1'b0;
      vc_reg     <= 1'b0;
    end else if (cclk_fall) begin
      pipe_a_reg <= corr_code;
      va_reg     <= 1'b1;
    end else if (cclk_rise) begin
      pipe_b_reg <= pipe_a_reg;
      pipe_c_reg <= pipe_b_reg;
      vb_reg     <= va_reg;
      vc_reg     <= vb_reg;
    end
  end

  // third rising edge after sampling offers the word
  vcd_stream_if #(.W(CHANS*8)) buf_in ();
  vcd_stream_if #(.W(CHANS*8)) buf_out ();
  assign buf_in.data  = pipe_c_reg;
  assign buf_in.valid = cclk_rise && vc_reg;
  assign in_ready     = buf_in.ready;
  assign out_data     = buf_out.data;
  assign out_valid    = buf_out.valid;
  assign buf_out.ready = out_ready;

  vcd_skid_buf #(.W(CHANS*8)) u_buf (
    .ref_clk (ref_clk),
    .srst    (srst),
    .in_s    (buf_in),
    .out_s   (buf_out)
  );
endmodule : vcd_ctrl

// ### vcd_ctrl_asserts.sv
`timescale 1ns/1ns
module vcd_ctrl_asserts #(
  parameter int unsigned CHANS = 3
) (
  // clock and reset
  input wire logic               ref_clk,
  input wire logic               srst,
  // pins
  input wire logic               line_sync_input,
  input wire logic               frame_sync_input,
  input wire logic               mode_pin_level,
  input wire logic               mode_pin_open,
  input wire logic [CHANS-1:0]   integ_sign,
  // outputs
  input wire logic               clamp_integrate,
  input wire logic [CHANS*8-1:0] clamp_ref_code,
  input wire logic [CHANS-1:0]   clamp_sink,
  input wire logic [CHANS-1:0]   clamp_source,
  input wire logic signed [2:0]  dither_half_steps,
  input wire logic [CHANS*8-1:0] out_data,
  input wire logic               out_valid,
  input wire logic               out_ready
);
  // ======
  // pins pass a filter, so levels are held several cycles first
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_mode_rgb: assert property ((!mode_pin_open && !mode_pin_level)[*8] |=>
    clamp_ref_code == 24'h10_1010) else $error("rgb clamp code wrong");
  a_mode_yuv: assert property ((!mode_pin_open && mode_pin_level)[*8] |=>
    clamp_ref_code == 24'h80_8010) else $error("yuv clamp code wrong");
  a_mode_open: assert property (mode_pin_open[*8] |=>
    clamp_ref_code == 24'h80_8040) else $error("open clamp code wrong");
  a_integ_on: assert property (line_sync_input[*6] |=> clamp_integrate)
    else $error("integrate missing");
  a_integ_off: assert property (!line_sync_input[*6] |=> !clamp_integrate)
    else $error("integrate stuck");
  a_sign_latch: assert property ($fell(clamp_integrate) |-> ##[0:2] clamp_sink == integ_sign)
    else $error("sign not latched");
  a_corr_sel: assert property ((|{clamp_sink, clamp_source}) |->
    clamp_sink == ~clamp_source && !clamp_integrate) else $error("bad correction");
  a_dither_off: assert property (!frame_sync_input[*6] |=> dither_half_steps == 3'sd0)
    else $error("dither while off");
  a_dither_set: assert property (dither_half_steps inside {3'sd0, 3'sd1, 3'sd2})
    else $error("dither out of set");
  a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("word not held");
endmodule : vcd_ctrl_asserts

// ### vcd_pix_sink.sv
`timescale 1ns/1ns
module vcd_pix_sink (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic srst,
  // stall request
  input  wire logic stall,
  // stream
  output logic      out_ready
);
  // ======
  // ready moves only after an edge, so a handshake is never cut short
  always_ff @(posedge ref_clk) begin
    out_ready <= !srst && !stall;
  end
endmodule : vcd_pix_sink

// ### testbench.sv
`timescale 1ns/1ns
module testbench;
  // ======
  // signals
  logic              ref_clk = 1'b0;
  logic              srst = 1'b1;
  logic              conv_clk_pin = 1'b1;
  logic              line_sync_input = 1'b0;
  logic              frame_sync_input = 1'b1;
  logic              mode_pin_level = 1'b0;
  logic              mode_pin_open = 1'b0;
  logic [23:0]       raw_code = 24'h00_0000;
  logic [2:0]        integ_sign = 3'b000;
  logic              clamp_integrate;
  logic [23:0]       clamp_ref_code;
  logic [2:0]        clamp_sink;
  logic [2:0]        clamp_source;
  logic signed [2:0] dither_half_steps;
  logic [23:0]       out_data;
  logic              out_valid;
  logic              out_ready;
  logic              in_ready;
  logic              stall = 1'b0;
  logic              hold = 1'b0;
  logic [15:0]       rnd = 16'h6E5F;
  int                err_total = 0;
  int                check_count = 0;
  int                dcnt = 0;
  int                fpar = 0;
  int                drained = 0;
  logic [23:0]       exp_q[$];
  always #10 ref_clk = ~ref_clk;
  vcd_ctrl i_dut (.ref_clk(ref_clk), .srst(srst), .conv_clk_pin(conv_clk_pin),
    .line_sync_input(line_sync_input), .frame_sync_input(frame_sync_input),
    .mode_pin_level(mode_pin_level), .mode_pin_open(mode_pin_open), .raw_code(raw_code),
    .integ_sign(integ_sign), .clamp_integrate(clamp_integrate),
    .clamp_ref_code(clamp_ref_code), .clamp_sink(clamp_sink), .clamp_source(clamp_source),
    .dither_half_steps(dither_half_steps), .out_data(out_data), .out_valid(out_valid),
    .out_ready(out_ready), .in_ready(in_ready));
  vcd_pix_sink i_sink (.ref_clk(ref_clk), .srst(srst), .stall(stall), .out_ready(out_ready));
  // ======
  // helpers
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr_next
  task automatic ticks(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : ticks
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test();
    if (err_total == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  // one conversion: level 8 cycles each, raw held across the capture
  task automatic sample(input logic [23:0] raw);
    logic [7:0]         w;
    logic [23:0]        e;
    vcd_pkg::vcd_half_t h;
    h = !frame_sync_input ? 3'sh0 :
      dcnt == 0 ? vcd_pkg::DITH_HALF0 : dcnt == 1 ? vcd_pkg::DITH_HALF1 :
      dcnt == 2 ? vcd_pkg::DITH_HALF2 : vcd_pkg::DITH_HALF3;
    w = 8'(h >>> 1);
    chk({21'h0, dither_half_steps}, {21'h0, h});
    for (int c = 0; c < 3; c++) e[c*8 +: 8] = raw[c*8 +: 8] < w ? 8'h00 : raw[c*8 +: 8] - w;
    @(posedge ref_clk);
    conv_clk_pin <= 1'b0;
    raw_code     <= raw;
    ticks(8);
    exp_q.push_back(e);
    conv_clk_pin <= 1'b1;
    ticks(8);
  endtask : sample
  // short pulse that ends well before the line's samples
  task automatic line();
    logic [2:0] s;
    s = rnd[2:0];
    @(posedge ref_clk);
    line_sync_input <= 1'b1;
    integ_sign      <= s;
    dcnt = (dcnt + 1) % 4;
    ticks(10);
    chk({23'h00_0000, clamp_integrate}, 24'h00_0001);
    line_sync_input <= 1'b0;
    ticks(10);
    chk({18'h0_0000, clamp_sink, clamp_source}, {18'h0_0000, s, ~s});
  endtask : line
  task automatic frame_pulse(input int n);
    @(posedge ref_clk);
    frame_sync_input <= 1'b0;
    if (fpar == 1) dcnt = 0;
    fpar = 1 - fpar;
    ticks(10);
    repeat (n) sample({rnd[7:0], rnd});
    frame_sync_input <= 1'b1;
    ticks(10);
  endtask : frame_pulse
  // ======
  // random stall and output monitor
  always @(posedge ref_clk) begin
    rnd   <= lfsr_next(rnd);
    stall <= hold | rnd[3];
    if (!srst && out_valid === 1'b1 && out_ready === 1'b1) begin
      drained++;
      chk(out_data, exp_q.size() > 0 ? exp_q.pop_front() : ~out_data);
    end
  end
  initial begin
    ticks(20000);
    err_total++;
    stop_test();
  end
  // ======
  // main sequence
  initial begin
    ticks(10);
    srst <= 1'b0;
    ticks(10);
    for (int m = 0; m < 3; m++) begin
      mode_pin_level <= (m == 1);
      mode_pin_open  <= (m == 2);
      ticks(20);
      chk(clamp_ref_code, m == 0 ? 24'h10_1010 : m == 1 ? 24'h80_8010 : 24'h80_8040);
    end
    for (int l = 0; l < 12; l++) begin
      line();
      ticks(10);
      sample(24'h00_FF01);
      sample(24'hFF_00FE);
      repeat (2) sample({rnd[7:0], rnd});
      if (l % 4 == 1) frame_pulse(2);
    end
    // full stall: two words kept, later ones refused
    ticks(100);
    chk(24'(exp_q.size()), 24'h00_0002);
    hold    <= 1'b1;
    drained = 0;
    repeat (6) sample({rnd[7:0], rnd});
    chk({23'h00_0000, in_ready}, 24'h00_0000);
    hold <= 1'b0;
    ticks(100);
    chk(24'(drained), 24'h00_0002);
    exp_q.delete();
    stop_test();
  end
endmodule : testbench
bind vcd_ctrl vcd_ctrl_asserts #(.CHANS(CHANS)) i_chk (.ref_clk(ref_clk), .srst(srst),
  .line_sync_input(line_sync_input), .frame_sync_input(frame_sync_input),
  .mode_pin_level(mode_pin_level), .mode_pin_open(mode_pin_open), .integ_sign(integ_sign),
  .clamp_integrate(clamp_integrate), .clamp_ref_code(clamp_ref_code),
  .clamp_sink(clamp_sink), .clamp_source(clamp_source),
  .dither_half_steps(dither_half_steps), .out_data(out_data), .out_valid(out_valid),
  .out_ready(out_ready));
